/* File: rtl/ttd_timing_dist.sv */
`timescale 1ns/1ps
`default_nettype none


module ttd_timing_dist
	import ttd_pkg::*;
#(
	parameter int NUM_CP_INPUTS = 8,
	parameter int FIFO_DEPTH = PIPE_DEPTH,
	parameter int FIFO_AW = PIPE_CNT_WIDTH
) (
	input wire logic sys_clk,
	input wire logic sys_rst,
	input wire logic deskewedClockA,
	input wire logic deskewedClockB,
	input wire logic crystalClk,
	input wire logic level1Accept,
	input wire logic bunchCounterReset,
	input wire logic pipelineReadoutCounterReset,
	input wire logic broadcastStrobe,
	input wire logic [CMD_WIDTH-1:0] broadcastCmd,
	input wire logic [CMD_WIDTH-1:0] timingData,
	input wire logic testMode,
	input wire logic [2*NUM_CP_INPUTS-1:0] phaseSelect,
	output logic tickA,
	output logic tickB,
	output logic rxClkEn,
	output logic [NUM_CP_INPUTS-1:0] captureEn,
	output logic [CP_FANOUT_PHASES-1:0] cpPhaseEn,
	output logic [BC_WIDTH-1:0] bunchCount,
	output logic [PIPE_CNT_WIDTH-1:0] pipelineCount,
	output logic pipeResetRoc,
	output logic pipeResetSer,
	output logic pipeResetCp,
	output logic daqReadoutStart,
	output logic roiReadoutStart,
	output logic playbackStart,
	output ttd_cmd_t busCmd,
	output logic tagValid,
	output logic [BC_WIDTH-1:0] tagWord,
	output logic fifoOverflow,
	output logic serDone,
	output logic cpDone
);

	// ----------------------------------------------------------------
	// pin synchronisers
	// ----------------------------------------------------------------
	localparam int NSYNC = 7;
	// first stage, read only by second stage
	logic [NSYNC-1:0] syncA_q;
	// second stage, safe to use
	logic [NSYNC-1:0] syncB_q;
	// previous value for edge finding
	logic [NSYNC-1:0] syncPrev_q;
	logic [NSYNC-1:0] pinsIn;
	logic [NSYNC-1:0] rise;

	assign pinsIn = {broadcastStrobe, pipelineReadoutCounterReset, bunchCounterReset,
		level1Accept, crystalClk, deskewedClockB, deskewedClockA};
	assign rise = syncB_q & ~syncPrev_q;

	// two flops per pin, third flop only for edges
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			syncA_q <= '0;
			syncB_q <= '0;
			syncPrev_q <= '0;
		end else begin
			syncA_q <= pinsIn;
			syncB_q <= syncA_q;
			syncPrev_q <= syncB_q;
		end
	end

	// broadcast payloads are held stable by the receiver around its strobe
	logic [CMD_WIDTH-1:0] cmdSyncA_q, cmdSyncB_q, dataSyncA_q, dataSyncB_q;
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			cmdSyncA_q <= '0;
			cmdSyncB_q <= '0;
			dataSyncA_q <= '0;
			dataSyncB_q <= '0;
		end else begin
			cmdSyncA_q <= broadcastCmd;
			cmdSyncB_q <= cmdSyncA_q;
			dataSyncA_q <= timingData;
			dataSyncB_q <= dataSyncA_q;
		end
	end

	// ----------------------------------------------------------------
	// machine clock ticks
	// ----------------------------------------------------------------
	// ticks from clock edges
	logic tickAEv, tickBEv, xtalTick;
	assign tickAEv = rise[0];
	assign tickBEv = rise[1];
	assign xtalTick = rise[2];

	// strobes are taken straight from their synchronised rising edges, not gated by any tick
	ttd_strobes_t strb;
	assign strb.accept = rise[3];
	assign strb.bcReset = rise[4];
	assign strb.pipeReset = rise[5];

	assign tickA = tickAEv;
	assign tickB = tickBEv;
	assign rxClkEn = tickAEv;

	// ----------------------------------------------------------------
	// capture phases for the processors
	// ----------------------------------------------------------------
	// tick B and its two delayed copies give the three fan-out phases; tick A, its
	// delayed copies and one delayed tick B give the four capture phases
	logic [CP_FANOUT_PHASES-1:0] tickBDly_q;
	logic tickADly_q;
	logic [PHASE_OFFSET_CYC-1:0] offsetDly_q;
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			tickBDly_q <= '0;
			tickADly_q <= 1'b0;
			offsetDly_q <= '0;
		end else begin
			tickBDly_q <= {tickBDly_q[CP_FANOUT_PHASES-2:0], tickBEv};
			tickADly_q <= tickAEv;
			offsetDly_q <= PHASE_OFFSET_CYC'({offsetDly_q, tickAEv});
		end
	end

	assign cpPhaseEn = {tickBDly_q[1:0], tickBEv};

	logic [CAPTURE_PHASES-1:0] capPhase;
	assign capPhase = {tickBDly_q[0], tickADly_q, offsetDly_q[PHASE_OFFSET_CYC-1], tickAEv};

	genvar gi;
	generate
		for (gi = 0; gi < NUM_CP_INPUTS; gi++) begin : g_cap
			assign captureEn[gi] = capPhase[phaseSelect[2*gi +: 2]];
		end
	endgenerate

	// ----------------------------------------------------------------
	// latency budget timers
	// ----------------------------------------------------------------
	logic [SER_LAT_CYC-1:0] serDly_q;
	logic [CP_LAT_CYC-1:0] cpDly_q;
	// data advance strobes, fire within the stage budgets
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			serDly_q <= '0;
			cpDly_q <= '0;
		end else begin
			serDly_q <= SER_LAT_CYC'({serDly_q, tickAEv});
			cpDly_q <= CP_LAT_CYC'({cpDly_q, tickBEv});
		end
	end
	assign serDone = serDly_q[SER_LAT_CYC-1];
	assign cpDone = cpDly_q[CP_LAT_CYC-1];

	// ----------------------------------------------------------------
	// bunch and pipeline counters
	// ----------------------------------------------------------------
	logic [BC_WIDTH-1:0] bunchCount_q;
	// reset wins over the tick so a clear is never lost
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			bunchCount_q <= BC_RESET_VAL;
		end else if (strb.bcReset) begin
			bunchCount_q <= BC_RESET_VAL;
		end else if (tickAEv) begin
			bunchCount_q <= bunchCount_q + 12'h001;
		end
	end
	assign bunchCount = bunchCount_q;

	logic [PIPE_CNT_WIDTH-1:0] pipeCount_q;
	// wraps every 128 ticks, realigned by the pipeline reset
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			pipeCount_q <= PIPE_RESET_VAL;
		end else if (strb.pipeReset) begin
			pipeCount_q <= PIPE_RESET_VAL;
		end else if (tickAEv) begin
			pipeCount_q <= pipeCount_q + 7'h01;
		end
	end
	assign pipelineCount = pipeCount_q;

	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			pipeResetRoc <= 1'b0;
			pipeResetSer <= 1'b0;
			pipeResetCp <= 1'b0;
		end else begin
			pipeResetRoc <= strb.pipeReset;
			pipeResetSer <= strb.pipeReset;
			pipeResetCp <= strb.pipeReset;
		end
	end

	// ----------------------------------------------------------------
	// accept handling and broadcast commands
	// ----------------------------------------------------------------
	// start both readouts
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			daqReadoutStart <= 1'b0;
			roiReadoutStart <= 1'b0;
		end else begin
			daqReadoutStart <= strb.accept;
			roiReadoutStart <= strb.accept;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			busCmd <= '0;
		end else begin
			busCmd.valid <= rise[6];
			if (rise[6]) begin
				busCmd.code <= cmdSyncB_q;
				busCmd.data <= dataSyncB_q;
			end
		end
	end

	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			playbackStart <= 1'b0;
		end else begin
			playbackStart <= rise[6] && testMode && (cmdSyncB_q == CMD_PLAYBACK);
		end
	end

	// ----------------------------------------------------------------
	// retiming FIFO toward the crystal-timed readout link
	// ----------------------------------------------------------------
	typedef enum {RD_IDLE, RD_FETCH, RD_SEND} ttd_rd_state_t;
	ttd_rd_state_t rdState_q;
	logic [FIFO_AW:0] wrPtr_q, rdPtr_q;
	logic fifoFull, fifoEmpty, wrEn, rdEn;
	logic [BC_WIDTH-1:0] memRdData;

	assign fifoEmpty = (wrPtr_q == rdPtr_q);
	assign fifoFull = (wrPtr_q[FIFO_AW] != rdPtr_q[FIFO_AW])
		&& (wrPtr_q[FIFO_AW-1:0] == rdPtr_q[FIFO_AW-1:0]);
	assign wrEn = strb.accept && !fifoFull;
	assign rdEn = (rdState_q == RD_IDLE) && xtalTick && !fifoEmpty;

	ttd_fifo_mem #(
		.WIDTH(BC_WIDTH),
		.DEPTH(FIFO_DEPTH),
		.AW(FIFO_AW)
	) u_mem (
		.sys_clk(sys_clk),
		.wrEn(wrEn),
		.wrAddr(wrPtr_q[FIFO_AW-1:0]),
		.wrData(bunchCount_q),
		.rdEn(rdEn),
		.rdAddr(rdPtr_q[FIFO_AW-1:0]),
		.rdData(memRdData)
	);

	// pointers, one per side of the store
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			wrPtr_q <= '0;
			rdPtr_q <= '0;
		end else begin
			if (wrEn) begin
				wrPtr_q <= wrPtr_q + 1'b1;
			end
			if (rdEn) begin
				rdPtr_q <= rdPtr_q + 1'b1;
			end
		end
	end

	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			fifoOverflow <= 1'b0;
		end else if (strb.accept && fifoFull) begin
			fifoOverflow <= 1'b1;
		end
	end

	// read side paced by crystal ticks, one tag per crystal period
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			rdState_q <= RD_IDLE;
			tagValid <= 1'b0;
			tagWord <= '0;
		end else begin
			tagValid <= 1'b0;
			case (rdState_q)
				RD_IDLE: begin
					if (rdEn) begin
						rdState_q <= RD_FETCH;
					end
				end
				RD_FETCH: begin
					// memory output settles this cycle
					rdState_q <= RD_SEND;
				end
				RD_SEND: begin
					tagValid <= 1'b1;
					tagWord <= memRdData;
					rdState_q <= RD_IDLE;
				end
				default: begin
					rdState_q <= RD_IDLE;
				end
			endcase
		end
	end

endmodule

`default_nettype wire

/* File: rtl/ttd_pkg.sv */
package ttd_pkg;

	// ----------------------------------------------------------------
	// clock rates and time figures
	// ----------------------------------------------------------------
	localparam int SYS_CLK_MHZ = 50;
	// machine clock, kHz
	localparam int MACHINE_CLK_KHZ = 40080;
	// readout crystal, kHz
	localparam int CRYSTAL_CLK_KHZ = 40000;
	// offset between the two processor clocks, ps
	localparam int PHASE_OFFSET_PS = 1560;
	// serialiser resync budget, ns
	localparam int SER_LAT_NS = 50;
	// processor resync plus algorithm budget, ns
	localparam int CP_LAT_NS = 165;

	// least time rounds up, never below one cycle
	localparam int PHASE_OFFSET_CYC_RAW = (PHASE_OFFSET_PS * SYS_CLK_MHZ + 999999) / 1000000;
	localparam int PHASE_OFFSET_CYC = (PHASE_OFFSET_CYC_RAW < 1) ? 1 : PHASE_OFFSET_CYC_RAW;
	// longest times round down, never below one cycle
	localparam int SER_LAT_CYC_RAW = (SER_LAT_NS * SYS_CLK_MHZ) / 1000;
	localparam int SER_LAT_CYC = (SER_LAT_CYC_RAW < 1) ? 1 : SER_LAT_CYC_RAW;
	localparam int CP_LAT_CYC_RAW = (CP_LAT_NS * SYS_CLK_MHZ) / 1000;
	localparam int CP_LAT_CYC = (CP_LAT_CYC_RAW < 1) ? 1 : CP_LAT_CYC_RAW;

	// ----------------------------------------------------------------
	// counters, depths and reset values
	// ----------------------------------------------------------------
	localparam int BC_WIDTH = 12;
	localparam int PIPE_DEPTH = 128;
	localparam int PIPE_CNT_WIDTH = 7;
	localparam logic [BC_WIDTH-1:0] BC_RESET_VAL = 12'h000;
	localparam logic [PIPE_CNT_WIDTH-1:0] PIPE_RESET_VAL = 7'h00;
	localparam int CP_FANOUT_PHASES = 3;
	localparam int CAPTURE_PHASES = 4;
	localparam int CMD_WIDTH = 8;
	// broadcast code that starts serialiser playback in test mode
	localparam logic [CMD_WIDTH-1:0] CMD_PLAYBACK = 8'h01;

	// ----------------------------------------------------------------
	// carriers
	// ----------------------------------------------------------------
	typedef struct packed {
		logic accept;
		logic bcReset;
		logic pipeReset;
	} ttd_strobes_t;

	typedef struct packed {
		logic valid;
		logic [CMD_WIDTH-1:0] code;
		logic [CMD_WIDTH-1:0] data;
	} ttd_cmd_t;

endpackage

/* File: rtl/ttd_fifo_mem.sv */
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------------------------------
// simple dual-port store with registered read data
// ----------------------------------------------------------------
module ttd_fifo_mem #(
	parameter int WIDTH = 12,
	parameter int DEPTH = 128,
	parameter int AW = 7
) (
	input wire logic sys_clk,
	input wire logic wrEn,
	input wire logic [AW-1:0] wrAddr,
	input wire logic [WIDTH-1:0] wrData,
	input wire logic rdEn,
	input wire logic [AW-1:0] rdAddr,
	output logic [WIDTH-1:0] rdData
);

	// storage array, no reset so it maps to block ram
	logic [WIDTH-1:0] mem [DEPTH];

	// write port
	always_ff @(posedge sys_clk) begin
		if (wrEn) begin
			mem[wrAddr] <= wrData;
		end
	end

	// read port, data valid the cycle after rdEn
	always_ff @(posedge sys_clk) begin
		if (rdEn) begin
			rdData <= mem[rdAddr];
		end
	end

endmodule

`default_nettype wire

/* File: tb/ttd_timing_dist_checker.sv */
`timescale 1ns/1ps
`default_nettype none
module ttd_timing_dist_checker
	import ttd_pkg::*;
(
	input wire logic sys_clk,
	input wire logic sys_rst,
	input wire logic deskewedClockA,
	input wire logic level1Accept,
	input wire logic bunchCounterReset,
	input wire logic broadcastStrobe,
	input wire logic testMode,
	input wire logic tickA,
	input wire logic tickB,
	input wire logic rxClkEn,
	input wire logic [CP_FANOUT_PHASES-1:0] cpPhaseEn,
	input wire logic [BC_WIDTH-1:0] bunchCount,
	input wire logic pipeResetRoc,
	input wire logic pipeResetSer,
	input wire logic pipeResetCp,
	input wire logic daqReadoutStart,
	input wire logic roiReadoutStart,
	input wire logic playbackStart,
	input wire ttd_cmd_t busCmd,
	input wire logic fifoOverflow,
	input wire logic serDone,
	input wire logic cpDone
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (sys_rst);
	// --------------------------------
	// ticks and budgets
	// --------------------------------
	tick_follows_pin_a: assert property ($rose(deskewedClockA) |-> ##[2:4] tickA)
		else $error("clock A rise gave no tick");
	rx_enable_a: assert property (rxClkEn == tickA)
		else $error("receiver enable not on tick A");
	ser_budget_a: assert property (tickA |-> ##2 serDone)
		else $error("serialiser stage late");
	cp_budget_a: assert property (tickB |-> ##8 cpDone)
		else $error("processor stage late");
	cp_phases_a: assert property (cpPhaseEn == {$past(tickB, 2), $past(tickB), tickB})
		else $error("processor phases wrong");
	// --------------------------------
	// strobes and commands
	// --------------------------------
	accept_cause_a: assert property (daqReadoutStart |-> $past(level1Accept) && $past(level1Accept, 2))
		else $error("readout start without accept");
	both_readouts_a: assert property (daqReadoutStart == roiReadoutStart)
		else $error("readout starts differ");
	pipe_fanout_a: assert property (pipeResetRoc == pipeResetSer && pipeResetRoc == pipeResetCp)
		else $error("pipeline reset fanout differs");
	bunch_clear_a: assert property ($rose(bunchCounterReset) |-> ##[2:5] bunchCount == BC_RESET_VAL)
		else $error("bunch counter not cleared");
	bunch_step_a: assert property ($changed(bunchCount) && bunchCount != BC_RESET_VAL |-> bunchCount == $past(bunchCount) + 12'h001)
		else $error("bunch counter jumped");
	cmd_forward_a: assert property ($rose(broadcastStrobe) |-> ##[2:5] busCmd.valid)
		else $error("broadcast not forwarded");
	playback_gate_a: assert property (playbackStart |-> busCmd.valid && busCmd.code == CMD_PLAYBACK && $past(testMode))
		else $error("playback without cause");
	overflow_sticky_a: assert property (fifoOverflow |=> fifoOverflow)
		else $error("overflow flag dropped");
	cover property (daqReadoutStart);
	cover property (playbackStart);
	cover property ($rose(fifoOverflow));
endmodule
bind ttd_timing_dist ttd_timing_dist_checker chk (
	.sys_clk, .sys_rst, .deskewedClockA, .level1Accept, .bunchCounterReset, .broadcastStrobe,
	.testMode, .tickA, .tickB, .rxClkEn, .cpPhaseEn, .bunchCount, .pipeResetRoc, .pipeResetSer,
	.pipeResetCp, .daqReadoutStart, .roiReadoutStart, .playbackStart, .busCmd, .fifoOverflow,
	.serDone, .cpDone
);
`default_nettype wire

/* File: tb/ttd_timing_source.sv */
`timescale 1ns/1ps
`default_nettype none
// stands in for the timing receiver: free-running machine clocks, crystal
module ttd_timing_source (
	output logic clkA,
	output logic clkB,
	output logic xtal,
	output logic pipeRst,
	input wire logic xtalRun
);
	int nTick = 0;
	// two machine clocks, second trails by the capture offset
	initial begin
		clkA = 1'b0;
		clkB = 1'b0;
		forever begin
			#78.44 clkA = ~clkA;
			#1.56 clkB = clkA;
		end
	end
	// crystal slightly slower; stands still while stalled
	initial begin
		xtal = 1'b0;
		forever #80.16 if (xtalRun) xtal = ~xtal;
	end
	// counter reset every 128 ticks, launched on the falling half
	initial pipeRst = 1'b0;
	always @(negedge clkA) begin
		nTick <= nTick + 1;
		pipeRst <= ((nTick + 1) % 128 == 0);
	end
endmodule
`default_nettype wire

/* File: tb/ttd_timing_dist_test.sv */
`timescale 1ns/1ps
`default_nettype none
module ttd_timing_dist_test;
	import ttd_pkg::*;
	logic sys_clk, sys_rst, clkA, clkB, xtal, pipeRst, xtalRun;
	logic accept, bcRst, strobe, testMode, tickA;
	logic [7:0] capEn;
	logic [15:0] phaseSel;
	logic [7:0] cmd, data;
	logic [BC_WIDTH-1:0] bunchCount, tagWord;
	logic [PIPE_CNT_WIDTH-1:0] pipelineCount;
	logic pipeResetRoc, pipeResetSer, pipeResetCp, daqStart, playbackStart, tagValid, fifoOverflow;
	ttd_cmd_t busCmd;
	int n_errors = 0;
	int checks_done = 0;
	ttd_timing_source src (.clkA(clkA), .clkB(clkB), .xtal(xtal), .pipeRst(pipeRst),
		.xtalRun(xtalRun));
	ttd_timing_dist uut (.sys_clk(sys_clk), .sys_rst(sys_rst), .deskewedClockA(clkA),
		.deskewedClockB(clkB), .crystalClk(xtal), .level1Accept(accept),
		.bunchCounterReset(bcRst), .pipelineReadoutCounterReset(pipeRst),
		.broadcastStrobe(strobe), .broadcastCmd(cmd), .timingData(data), .testMode(testMode),
		.phaseSelect(phaseSel), .tickA(tickA), .tickB(), .rxClkEn(), .captureEn(capEn),
		.cpPhaseEn(),
		.bunchCount(bunchCount), .pipelineCount(pipelineCount), .pipeResetRoc(pipeResetRoc),
		.pipeResetSer(pipeResetSer), .pipeResetCp(pipeResetCp), .daqReadoutStart(daqStart),
		.roiReadoutStart(), .playbackStart(playbackStart), .busCmd(busCmd),
		.tagValid(tagValid), .tagWord(tagWord), .fifoOverflow(fifoOverflow), .serDone(),
		.cpDone());
	initial begin
		sys_clk = 1'b0;
		forever #10 sys_clk = ~sys_clk;
	end
	task automatic cmp(input string what, input logic [15:0] exp, input logic [15:0] got);
		checks_done++;
		if (got !== exp) begin
			n_errors++;
			$display("[ERR] %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic summarize;
		$display("checks %0d errors %0d", checks_done, n_errors);
		if (n_errors == 0 && checks_done > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	// clear the bunch count, let n machine ticks pass, then accept one event
	task automatic t_tag(input int n);
		int i;
		@(posedge clkA);
		@(negedge sys_clk);
		bcRst = 1'b1;
		repeat (4) @(negedge sys_clk);
		bcRst = 1'b0;
		repeat (n) @(posedge clkA);
		// keep the accept clear of the counter step of that tick
		repeat (4) @(negedge sys_clk);
		accept = 1'b1;
		for (i = 0; i < 20 && daqStart !== 1'b1; i++) @(negedge sys_clk);
		cmp("readout start", 16'h1, 16'(daqStart));
		cmp("bunch count", 16'(n % 4096), 16'(bunchCount));
		repeat (2) @(negedge sys_clk);
		accept = 1'b0;
		for (i = 0; i < 200 && tagValid !== 1'b1; i++) @(negedge sys_clk);
		cmp("tag word", 16'(n % 4096), 16'(tagWord));
		$display("tag test %0d done", n);
	endtask
	task automatic t_bcast(input logic tm, input logic [7:0] c);
		int i;
		testMode = tm;
		cmd = c;
		data = ~c;
		repeat (4) @(negedge sys_clk);
		strobe = 1'b1;
		for (i = 0; i < 20 && busCmd.valid !== 1'b1; i++) @(negedge sys_clk);
		cmp("cmd valid", 16'h1, 16'(busCmd.valid));
		cmp("cmd word", {c, ~c}, {busCmd.code, busCmd.data});
		cmp("playback", 16'(tm && c == CMD_PLAYBACK), 16'(playbackStart));
		repeat (2) @(negedge sys_clk);
		strobe = 1'b0;
		repeat (3) @(negedge sys_clk);
		$display("broadcast test %h done", c);
	endtask
	task automatic t_pipe;
		int i;
		for (i = 0; i < 1100 && pipeResetRoc !== 1'b1; i++) @(negedge sys_clk);
		cmp("reset fanout", 16'h7, 16'({pipeResetRoc, pipeResetSer, pipeResetCp}));
		cmp("pipe count", 16'(PIPE_RESET_VAL), 16'(pipelineCount));
		@(negedge sys_clk);
		for (i = 1; i < 1100 && pipeResetRoc !== 1'b1; i++) @(negedge sys_clk);
		cmp("reset period", 16'(128 * 8), 16'(i));
		$display("pipeline reset test done");
	endtask
	// crystal stalled: 128 accepts fit, the next one overflows, then drain
	task automatic t_fill;
		int i;
		int n;
		xtalRun = 1'b0;
		n = 0;
		repeat (20) @(negedge sys_clk);
		for (i = 0; i < 129; i++) begin
			cmp("overflow", 16'h0, 16'(fifoOverflow));
			accept = 1'b1;
			repeat (5) @(negedge sys_clk);
			accept = 1'b0;
			repeat (2) @(negedge sys_clk);
		end
		cmp("overflow", 16'h1, 16'(fifoOverflow));
		xtalRun = 1'b1;
		for (i = 0; i < 4000; i++) begin
			@(negedge sys_clk);
			n += (tagValid === 1'b1);
		end
		cmp("tags drained", 16'(PIPE_DEPTH), 16'(n));
		$display("fill test done");
	endtask
	// inputs 0..3 pick phases 0..3; clock B trails A inside one sample
	task automatic t_phase;
		int i;
		for (i = 0; i < 20 && tickA !== 1'b1; i++) @(negedge sys_clk);
		cmp("capture on tick", 16'h1, 16'(capEn[3:0]));
		@(negedge sys_clk);
		cmp("capture after tick", 16'he, 16'(capEn[3:0]));
		$display("phase test done");
	endtask
	initial begin
		repeat (80000) @(posedge sys_clk);
		n_errors++;
		summarize();
	end
	initial begin
		sys_rst = 1'b1;
		{accept, bcRst, strobe, testMode} = 4'h0;
		xtalRun = 1'b1;
		phaseSel = 16'h00e4;
		cmd = 8'h00;
		data = 8'h00;
		repeat (12) @(negedge sys_clk);
		sys_rst = 1'b0;
		repeat (4) @(negedge sys_clk);
		t_phase();
		t_tag(3);
		t_tag(4097);
		for (int m = 0; m < 2; m++) begin
			t_bcast(1'(m), CMD_PLAYBACK);
			t_bcast(1'(m), 8'h02);
		end
		t_pipe();
		t_fill();
		summarize();
	end
endmodule
`default_nettype wire
